// ===== pkg/keypad_pkg.sv
// Package holding register map, field positions and carrier types of the keypad interrupt unit.
package keypad_pkg;
    localparam int PIN_COUNT = 8;
    localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_PIN_ENABLE = 4'h4;
    localparam logic [3:0] OFS_EDGE_SELECT = 4'h8;
    localparam int BIT_DETECT_FLAG = 3;
    localparam int BIT_FLAG_ACK = 2;
    localparam int BIT_IRQ_ENABLE = 1;
    localparam int BIT_LEVEL_MODE = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] prev;
        logic armed;
        logic detect_flag;
        logic irq_enable;
        logic level_mode_select;
        logic [7:0] pin_enable_bits;
        logic [7:0] polarity_bits;
        logic aw_held;
        logic [3:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } keypad_state_t;
endpackage

// ===== src/keypad_interrupt_unit.sv
// Keypad interrupt unit with AXI4-Lite register access.
//
// Functional notes
// - Status bits 7:4 read as zero.
// - Detect flag reads status, ignores writes.
// - Acknowledge bit write-one clears, reads zero.
// - Irq enable gates request from flag.
// - Mode bit selects edges or edges+levels.
// - Pin enable bits select source pins.
// - Polarity bits choose falling/low or rising/high.
// - Edge means deasserted then asserted sample.
// - Rearm only when all enabled pins deasserted.
// - Edge mode: edge sets, acknowledge clears.
// - Level mode: edge or level sets.
// - Level mode: ack clears only if deasserted.
// - Polarity also picks pullup or pulldown.
// - Spurious flag on pin enable allowed.
// - Eight pins share one flag, one request.
// - Deep stop wake returns to reset state.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module keypad_interrupt_unit
    import keypad_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic STOP_DEEP_WAKE,
    input wire logic [PIN_COUNT-1:0] KEYPAD_INPUT_PINS,
    output logic [PIN_COUNT-1:0] PORT_PULL_DOWN,
    output logic IRQ,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    keypad_state_t st_r;
    keypad_state_t st_nxt;

    function automatic logic [7:0] status_byte(input keypad_state_t s);
        status_byte = {4'h0, s.detect_flag, 1'b0, s.irq_enable, s.level_mode_select};
    endfunction

    function automatic logic known_addr(input logic [3:0] a);
        known_addr = (a == OFS_STATUS_CONTROL) || (a == OFS_PIN_ENABLE)
            || (a == OFS_EDGE_SELECT);
    endfunction

    logic [7:0] asserted;
    logic [7:0] edge_hit;
    logic any_asserted;
    logic do_write;
    logic do_read;
    logic ack_write;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync1 = KEYPAD_INPUT_PINS;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev = st_r.sync2;
        asserted = (st_r.sync2 ~^ st_r.polarity_bits) & st_r.pin_enable_bits;
        edge_hit = asserted & ~((st_r.prev ~^ st_r.polarity_bits) & st_r.pin_enable_bits);
        // All enabled pins merge into one flag.
        any_asserted = |asserted;

        do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;
        do_read = S_AXI_ARVALID && !st_r.rvalid;
        ack_write = do_write && (st_r.aw_addr == OFS_STATUS_CONTROL) && st_r.w_strb[0]
            && st_r.w_data[BIT_FLAG_ACK];

        // Write address and data are taken independently in either order.
        if (S_AXI_AWVALID && !st_r.aw_held)
        begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = S_AXI_AWADDR[3:0];
        end
        if (S_AXI_WVALID && !st_r.w_held)
        begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = S_AXI_WDATA;
            st_nxt.w_strb = S_AXI_WSTRB;
        end
        if (do_write)
        begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = known_addr(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (st_r.w_strb[0])
            begin
                case (st_r.aw_addr)
                    OFS_STATUS_CONTROL:
                    begin
                        st_nxt.irq_enable = st_r.w_data[BIT_IRQ_ENABLE];
                        st_nxt.level_mode_select = st_r.w_data[BIT_LEVEL_MODE];
                    end
                    OFS_PIN_ENABLE: st_nxt.pin_enable_bits = st_r.w_data[7:0];
                    OFS_EDGE_SELECT: st_nxt.polarity_bits = st_r.w_data[7:0];
                    default: st_nxt.bresp = RESP_SLVERR;
                endcase
            end
        end
        if (st_r.bvalid && S_AXI_BREADY)
        begin
            st_nxt.bvalid = 1'b0;
        end

        if (do_read)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            case (S_AXI_ARADDR[3:0])
                OFS_STATUS_CONTROL: st_nxt.rdata = {24'h000000, status_byte(st_r)};
                OFS_PIN_ENABLE: st_nxt.rdata = {24'h000000, st_r.pin_enable_bits};
                OFS_EDGE_SELECT: st_nxt.rdata = {24'h000000, st_r.polarity_bits};
                default:
                begin
                    st_nxt.rdata = 32'h00000000;
                    st_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (st_r.rvalid && S_AXI_RREADY)
        begin
            st_nxt.rvalid = 1'b0;
        end

        // Rearm once all enabled pins deasserted.
        if (!any_asserted)
        begin
            st_nxt.armed = 1'b1;
        end
        // Level mode clear needs deasserted inputs.
        if (ack_write && (!st_r.level_mode_select || !any_asserted))
        begin
            st_nxt.detect_flag = 1'b0;
        end
        // Enabling a pin may set the flag; left as is.
        if (st_r.armed && (|edge_hit))
        begin
            st_nxt.detect_flag = 1'b1;
            st_nxt.armed = 1'b0;
        end
        // Level also sets in level mode.
        if (st_r.level_mode_select && any_asserted)
        begin
            st_nxt.detect_flag = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        // Deep stop wake resets all state.
        if (!RESET_N || STOP_DEEP_WAKE)
        begin
            st_r <= '0;
            st_r.pin_enable_bits <= RESET_BYTE;
            st_r.polarity_bits <= RESET_BYTE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Request only when enabled and flagged.
    assign IRQ = st_r.irq_enable && st_r.detect_flag;
    assign PORT_PULL_DOWN = st_r.polarity_bits;
    assign S_AXI_AWREADY = !st_r.aw_held;
    assign S_AXI_WREADY = !st_r.w_held;
    assign S_AXI_BVALID = st_r.bvalid;
    assign S_AXI_BRESP = st_r.bresp;
    assign S_AXI_ARREADY = !st_r.rvalid;
    assign S_AXI_RVALID = st_r.rvalid;
    assign S_AXI_RDATA = st_r.rdata;
    assign S_AXI_RRESP = st_r.rresp;
endmodule
`default_nettype wire

// ===== tb/keypad_props.sv
// Bus and request checker bound to the keypad interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module keypad_props (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic STOP_DEEP_WAKE,
    input wire logic [7:0] KEYPAD_INPUT_PINS,
    input wire logic IRQ,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N || STOP_DEEP_WAKE);
    property p_irq_fall; $fell(IRQ) |-> $rose(S_AXI_BVALID); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    property p_irq_rise; $rose(IRQ) && !$rose(S_AXI_BVALID) |-> $past(S_AXI_BVALID) ||
        $past(KEYPAD_INPUT_PINS, 3) != $past(KEYPAD_INPUT_PINS, 4); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_blat; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |->
        ##2 S_AXI_BVALID; endproperty
    a_blat: assert property (p_blat) else $error("write answer late");
    property p_bclr; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
    a_bclr: assert property (p_bclr) else $error("write answer kept");
    property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_rlat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_arready; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_arready: assert property (p_arready) else $error("read taken while busy");
    property p_rhi; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0; endproperty
    a_rhi: assert property (p_rhi) else $error("upper read bits set");
endmodule
bind keypad_interrupt_unit keypad_props u_keypad_props (.*);
`default_nettype wire

// ===== tb/keypad_switches.sv
// Key switches with the pin pull resistors.
`timescale 1ns/1ps
`default_nettype none
module keypad_switches (
    input wire logic [7:0] press,
    input wire logic [7:0] pull_down,
    output logic [7:0] pins
);
    assign pins = press ^ ~pull_down;
endmodule
`default_nettype wire

// ===== tb/keypad_interrupt_unit_tb.sv
// Self-checking bench of the keypad interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module keypad_interrupt_unit_tb;
    import keypad_pkg::*;
    logic CLK_SYS, RESET_N, STOP_DEEP_WAKE, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, IRQ;
    logic S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic S_AXI_ARREADY, S_AXI_RVALID;
    logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [7:0] KEYPAD_INPUT_PINS, PORT_PULL_DOWN, press;
    logic [25:0] row [4];
    int error_cnt, n_tests, cyc;
    keypad_interrupt_unit u_keypad_interrupt_unit (.*);
    keypad_switches u_keypad_switches (.press(press), .pull_down(PORT_PULL_DOWN),
        .pins(KEYPAD_INPUT_PINS));
    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic t(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic aw, w, b;
        logic [1:0] br;
        {S_AXI_AWADDR, S_AXI_WDATA} <= {28'h0, a, 24'h0, d};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        do
        begin
            @(negedge CLK_SYS);
            {aw, w, b} = {S_AXI_AWVALID & S_AXI_AWREADY, S_AXI_WVALID & S_AXI_WREADY, S_AXI_BVALID};
            br = S_AXI_BRESP;
            @(posedge CLK_SYS);
            if (aw) S_AXI_AWVALID <= 1'b0;
            if (w) S_AXI_WVALID <= 1'b0;
        end while (!b);
        chk("bresp", 32'(br), 32'((a == OFS_STATUS_CONTROL || a == OFS_PIN_ENABLE
            || a == OFS_EDGE_SELECT) ? RESP_OKAY : RESP_SLVERR));
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] r);
        logic [33:0] got;
        {S_AXI_ARADDR, S_AXI_ARVALID} <= {28'h0, a, 1'b1};
        do @(negedge CLK_SYS); while (!S_AXI_ARREADY);
        @(posedge CLK_SYS);
        S_AXI_ARVALID <= 1'b0;
        do @(negedge CLK_SYS); while (!S_AXI_RVALID);
        @(posedge CLK_SYS);
        S_AXI_RREADY <= 1'b1;
        @(negedge CLK_SYS);
        got = {S_AXI_RRESP, S_AXI_RDATA};
        @(posedge CLK_SYS);
        S_AXI_RREADY <= 1'b0;
        chk("read", got[31:0], {24'h0, e});
        chk("rresp", 32'(got[33:32]), 32'(r));
    endtask
    initial
    begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial
    begin
        logic m, f;
        logic [7:0] pol, en, p;
        {RESET_N, STOP_DEEP_WAKE, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, press} = '0;
        {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR} = '0;
        {S_AXI_WSTRB, error_cnt, n_tests, cyc} = {4'hF, 96'h0};
        row = '{{1'b0, 24'h000101, 1'b1}, {1'b0, 24'hFF8080, 1'b1},
            {1'b0, 24'h000102, 1'b0}, {1'b1, 24'h0F0F08, 1'b1}};
        t(2);
        RESET_N <= 1'b1;
        for (int a = 0; a < 12; a += 4) rd(a[3:0], 8'h00, RESP_OKAY);
        rd(4'hC, 8'h00, RESP_SLVERR);
        wr(4'hC, 8'hFF);
        foreach (row[i])
        begin
            {m, pol, en, p, f} = row[i];
            wr(4'h0, {7'h0, m});
            wr(4'h4, 8'h00);
            wr(4'h8, pol);
            wr(4'h4, en);
            wr(4'h0, {5'h0, 1'b1, 1'b0, m});
            wr(4'h0, {6'h1, m});
            press <= p;
            t(6);
            chk("irq", 32'(IRQ), 32'(f));
            rd(4'h0, {4'h0, f, 2'h1, m}, RESP_OKAY);
            chk("pull", 32'(PORT_PULL_DOWN), 32'(pol));
            press <= 8'h00;
            t(6);
            wr(4'h0, {5'h1, 1'b1, m});
            chk("irq", 32'(IRQ), 32'h0);
        end
        {pol, en} = {8'h00, 8'h03};
        wr(4'h0, 8'h00);
        wr(4'h8, pol);
        wr(4'h4, en);
        wr(4'h0, 8'h04);
        press <= 8'h01;
        t(6);
        wr(4'h0, 8'h04);
        press <= 8'h03;
        t(6);
        rd(4'h0, 8'h00, RESP_OKAY);
        press <= 8'h02;
        t(6);
        rd(4'h0, 8'h00, RESP_OKAY);
        press <= 8'h00;
        t(6);
        press <= 8'h02;
        t(6);
        rd(4'h0, 8'h08, RESP_OKAY);
        chk("irq", 32'(IRQ), 32'h0);
        wr(4'h0, 8'h05);
        rd(4'h0, 8'h09, RESP_OKAY);
        press <= 8'h00;
        t(6);
        wr(4'h0, 8'h05);
        wr(4'h0, 8'h09);
        rd(4'h0, 8'h01, RESP_OKAY);
        STOP_DEEP_WAKE <= 1'b1;
        t(1);
        STOP_DEEP_WAKE <= 1'b0;
        for (int a = 0; a < 12; a += 4) rd(a[3:0], 8'h00, RESP_OKAY);
        report_and_stop();
    end
endmodule
`default_nettype wire
